// ==== core/mibio_core.sv ====
// Executor for add, decimal adjust, inc/dec, dec-skip and global irq ops.
// Assumes the fetch stage offers one instruction per cycle; the core itself drops the
// prefetched one on a zero dec-skip and pulses SKIP_NEXT; registers sit on AXI4-Lite.
// Overview of operation
// RULE1 - Decimal adjust makes acc packed BCD, touches only carry, one cycle.
// RULE2 - Software places decimal adjust right after the addition it fixes.
// RULE3 - Software should mask interrupts around the add and decimal adjust.
// RULE4 - Dec-skip subtracts one, routes by dest bit, leaves flags alone.
// RULE5 - Zero dec-skip result discards prefetched instruction; takes 2 cycles.
// RULE6 - Decrement subtracts one, routes by dest bit, updates zero, one cycle.
// RULE7 - Increment adds one mod 256, routes by dest, updates zero, one cycle.
// RULE8 - Global irq off clears the enable bit, one cycle, flags unchanged.
// RULE9 - Global irq on sets the enable bit, one cycle, flags unchanged.
// RULE10 - Add six per nibble above nine or carrying; carry when above 99.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps

module mibio_core
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic INSTR_VALID,
    input wire mibio_pkg::mibio_instr_t INSTR,
    output logic SKIP_NEXT,
    output logic IRQ_EN_OUT,
    output logic [7:0] ACC_OUT,
    input wire logic [mibio_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [mibio_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import mibio_pkg::*;

    logic [7:0] acc_r, acc_nxt;
    mibio_flags_t flg_r, flg_nxt;
    mibio_instr_t ex_r;
    logic ex_vld_r;
    logic skip_r;
    logic [7:0] rd_data, opnd, res;
    logic fwd_hit_r;
    logic [7:0] fwd_data_r;
    logic core_wr, skip_now;
    logic [8:0] sum9, dadj_v;
    logic [4:0] half5;
    logic dadj_hi;
    logic mem_we;
    logic [5:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [8:0] last_r;
    logic [15:0] file_word_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_held_r, w_held_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic do_wr, lane0, sw_acc_we, sw_flg_we, sw_file_we, wr_map;

    // Outputs are the flip-flops themselves.
    assign SKIP_NEXT = skip_r;
    assign IRQ_EN_OUT = flg_r.irq_en;
    assign ACC_OUT = acc_r;
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    // The core owns the memory write port; a software write waits for it.
    assign mem_we = core_wr | sw_file_we;
    // The software word is taken from the held write data, because the
    // file word register only picks it up at the same edge.
    assign mem_waddr = core_wr ? ex_r.addr : w_data_r[13:8];
    assign mem_wdata = core_wr ? res : w_data_r[7:0];

    mibio_file_mem u_mem
    (
        .CLK_SYS(CLK_SYS),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(INSTR.addr),
        .rd_data(rd_data)
    );

    // The read is issued as the instruction loads, so a write landing in
    // that same cycle must be forwarded or the operand would be stale.
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            fwd_hit_r <= 1'b0;
            fwd_data_r <= ACC_RST;
        end
        else
        begin
            fwd_hit_r <= mem_we && (mem_waddr == INSTR.addr);
            fwd_data_r <= mem_wdata;
        end
    end

    assign opnd = fwd_hit_r ? fwd_data_r : rd_data;

    // Execute stage load; a skipped slot becomes an empty cycle (a nop).
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            ex_vld_r <= 1'b0;
            ex_r <= '0;
            skip_r <= 1'b0;
        end
        else
        begin
            ex_vld_r <= INSTR_VALID && !skip_now; // RULE5
            ex_r <= INSTR;
            skip_r <= skip_now; // RULE5
        end
    end

    // Operation results; software writes are the defaults so that an
    // executing instruction overrides a colliding software write.
    always_comb
    begin
        acc_nxt = sw_acc_we ? w_data_r[7:0] : acc_r;
        flg_nxt = sw_flg_we ? mibio_flags_t'(w_data_r[3:0]) : flg_r;
        res = opnd;
        core_wr = 1'b0;
        skip_now = 1'b0;
        sum9 = {1'b0, acc_r} + {1'b0, opnd};
        half5 = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]};
        dadj_v = {1'b0, acc_r};
        dadj_hi = 1'b0;
        if (ex_vld_r)
        begin
            case (ex_r.op)
                OP_ADD:
                begin
                    res = sum9[7:0];
                    flg_nxt.c = sum9[8];
                    flg_nxt.dc = half5[4];
                    flg_nxt.z = (sum9[7:0] == 8'h00);
                end
                OP_DADJ:
                begin
                    if ((acc_r[3:0] > BCD_MAX) || flg_r.dc)
                    begin
                        dadj_v = dadj_v + BCD_LO_FIX; // RULE10
                    end
                    dadj_hi = (dadj_v[8:4] > BCD_HI_MAX) || flg_r.c;
                    if (dadj_hi)
                    begin
                        dadj_v = dadj_v + BCD_HI_FIX; // RULE10
                    end
                    acc_nxt = dadj_v[7:0]; // RULE1
                    flg_nxt.c = dadj_hi; // RULE10
                end
                OP_DSZ:
                begin
                    res = opnd - ONE; // RULE4
                    skip_now = (res == 8'h00); // RULE5
                end
                OP_DEC:
                begin
                    res = opnd - ONE; // RULE6
                    flg_nxt.z = (res == 8'h00); // RULE6
                end
                OP_INC:
                begin
                    res = opnd + ONE; // RULE7
                    flg_nxt.z = (res == 8'h00); // RULE7
                end
                OP_IRQ_OFF:
                begin
                    flg_nxt.irq_en = 1'b0; // RULE8
                end
                OP_IRQ_ON:
                begin
                    flg_nxt.irq_en = 1'b1; // RULE9
                end
                default:
                begin
                    res = opnd;
                end
            endcase
            // Destination select for the file register operations.
            if (ex_r.op inside {OP_ADD, OP_DSZ, OP_DEC, OP_INC})
            begin
                if (ex_r.dest)
                begin
                    core_wr = 1'b1; // RULE4 RULE6 RULE7
                end
                else
                begin
                    acc_nxt = res; // RULE4 RULE6 RULE7
                end
            end
        end
    end

    // Accumulator, flags and the last result seen by software.
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            acc_r <= ACC_RST;
            flg_r <= FLAGS_RST;
            last_r <= '0;
        end
        else
        begin
            acc_r <= acc_nxt;
            flg_r <= flg_nxt;
            if (ex_vld_r && (ex_r.op inside {OP_ADD, OP_DSZ, OP_DEC, OP_INC}))
            begin
                last_r <= {skip_now, res};
            end
        end
    end

    // Write decode; the file word needs both low byte lanes.
    assign lane0 = w_strb_r[0];
    assign do_wr = aw_held_r && w_held_r && !bvalid_r
                   && !((aw_addr_r == ADDR_FILE) && ex_vld_r && ex_r.dest
                        && (ex_r.op inside {OP_ADD, OP_DSZ, OP_DEC, OP_INC}));
    assign sw_acc_we = do_wr && lane0 && (aw_addr_r == ADDR_ACC);
    assign sw_flg_we = do_wr && lane0 && (aw_addr_r == ADDR_FLAGS);
    assign sw_file_we = do_wr && (w_strb_r[1:0] == 2'h3)
                        && (aw_addr_r == ADDR_FILE);
    always_comb
    begin
        if (aw_addr_r == ADDR_ACC)
            wr_map = 1'b1;
        else if (aw_addr_r == ADDR_FLAGS)
            wr_map = 1'b1;
        else if (aw_addr_r == ADDR_FILE)
            wr_map = 1'b1;
        else
            wr_map = 1'b0;
    end

    // Write channels: address and data are taken in either order.
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            file_word_r <= FILE_WORD_RST;
        end
        else
        begin
            if (S_AXI_AWVALID && awready_r)
            begin
                aw_addr_r <= S_AXI_AWADDR;
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (S_AXI_WVALID && wready_r)
            begin
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (do_wr)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
                if (sw_file_we)
                begin
                    file_word_r <= w_data_r[15:0];
                end
            end
            if (bvalid_r && S_AXI_BREADY)
            begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Read channel: data one cycle after the address is taken.
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            if (S_AXI_ARADDR == ADDR_ACC)
                rdata_r <= {24'h000000, acc_r};
            else if (S_AXI_ARADDR == ADDR_FLAGS)
                rdata_r <= {28'h0000000, flg_r};
            else if (S_AXI_ARADDR == ADDR_FILE)
                rdata_r <= {16'h0000, file_word_r};
            else if (S_AXI_ARADDR == ADDR_LAST)
                rdata_r <= {23'h000000, last_r};
            else
            begin
                rdata_r <= '0;
                rresp_r <= RESP_SLVERR;
            end
        end
        else if (rvalid_r && S_AXI_RREADY)
        begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Checks on the executed operations.
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    logic is_dadj, is_dsz, is_dec, is_inc, is_off, is_on;
    assign is_dadj = ex_vld_r && (ex_r.op == OP_DADJ);
    assign is_dsz = ex_vld_r && (ex_r.op == OP_DSZ);
    assign is_dec = ex_vld_r && (ex_r.op == OP_DEC);
    assign is_inc = ex_vld_r && (ex_r.op == OP_INC);
    assign is_off = ex_vld_r && (ex_r.op == OP_IRQ_OFF);
    assign is_on = ex_vld_r && (ex_r.op == OP_IRQ_ON);

    property p_dadj_carry_only;
        is_dadj && !sw_flg_we |=> (flg_r.z == $past(flg_r.z))
            && (flg_r.irq_en == $past(flg_r.irq_en))
            && (flg_r.dc == $past(flg_r.dc));
    endproperty
    a_dadj_carry_only: assert property (p_dadj_carry_only) // RULE1
        else $error("Decimal adjust changed a flag other than carry.");

    property p_dadj_bcd_kept;
        is_dadj && !flg_r.c && !flg_r.dc && (acc_r[3:0] <= BCD_MAX)
            && (acc_r[7:4] <= BCD_MAX) |=> (acc_r == $past(acc_r)) && !flg_r.c;
    endproperty
    a_dadj_bcd_kept: assert property (p_dadj_bcd_kept) // RULE10
        else $error("Decimal adjust altered an already decimal value.");

    property p_dsz_acc;
        is_dsz && !ex_r.dest && !sw_flg_we |=>
            (acc_r == $past(opnd) - ONE) && (flg_r == $past(flg_r));
    endproperty
    a_dsz_acc: assert property (p_dsz_acc) // RULE4
        else $error("Dec-skip result or flags wrong.");

    sequence s_skip_hit;
        is_dsz && (opnd == ONE);
    endsequence
    sequence s_slot_dropped;
        SKIP_NEXT && !ex_vld_r ##1 !SKIP_NEXT;
    endsequence
    property p_skip_two_cycles;
        s_skip_hit |=> s_slot_dropped;
    endproperty
    a_skip_two_cycles: assert property (p_skip_two_cycles) // RULE5
        else $error("Zero dec-skip did not drop the prefetched slot.");

    property p_dec_acc;
        is_dec && !ex_r.dest |=>
            (acc_r == $past(opnd) - ONE) && (flg_r.z == (acc_r == 8'h00));
    endproperty
    a_dec_acc: assert property (p_dec_acc) // RULE6
        else $error("Decrement result or zero flag wrong.");

    property p_inc_reg;
        is_inc && ex_r.dest |-> mem_we && (mem_wdata == opnd + ONE)
            ##1 (flg_r.z == ($past(opnd) == 8'hFF));
    endproperty
    a_inc_reg: assert property (p_inc_reg) // RULE7
        else $error("Increment write-back or zero flag wrong.");

    property p_irq_off;
        is_off && !sw_flg_we |=> !IRQ_EN_OUT && (flg_r.c == $past(flg_r.c))
            && (flg_r.z == $past(flg_r.z));
    endproperty
    a_irq_off: assert property (p_irq_off) // RULE8
        else $error("Global irq off did not clear the enable bit.");

    property p_irq_on;
        is_on && !sw_flg_we |=> IRQ_EN_OUT && (flg_r.c == $past(flg_r.c))
            && (flg_r.z == $past(flg_r.z));
    endproperty
    a_irq_on: assert property (p_irq_on) // RULE9
        else $error("Global irq on did not set the enable bit.");

endmodule : mibio_core

// ==== core/mibio_file_mem.sv ====
// File register memory: one write port, one registered read port.
// Assumes the caller forwards data written in the same cycle as a read.
`timescale 1ns/10ps

module mibio_file_mem
(
    input wire logic CLK_SYS,
    input wire logic wr_en,
    input wire logic [mibio_pkg::FILE_AW-1:0] wr_addr,
    input wire logic [mibio_pkg::DATA_W-1:0] wr_data,
    input wire logic [mibio_pkg::FILE_AW-1:0] rd_addr,
    output logic [mibio_pkg::DATA_W-1:0] rd_data
);
    import mibio_pkg::*;

    logic [DATA_W-1:0] mem [FILE_DEPTH];

    // Write port; the contents are not reset, as in any register file.
    always_ff @(posedge CLK_SYS)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data come out of a register, one cycle after the address.
    always_ff @(posedge CLK_SYS)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule : mibio_file_mem

// ==== core/mibio_pkg.sv ====
// Shared constants and types of the inc/dec, decimal adjust and irq block.
// Assumes a single 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package mibio_pkg;

    // Data path and file register sizes.
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FILE_AW = 6;
    localparam int unsigned FILE_DEPTH = 64;
    localparam int unsigned AXI_AW = 8;

    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_ACC = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_FILE = 8'h08;
    localparam logic [7:0] ADDR_LAST = 8'h0C;

    // Field positions of the flags and file access words.
    localparam int unsigned FLG_C_POS = 0;
    localparam int unsigned FLG_Z_POS = 1;
    localparam int unsigned FLG_DC_POS = 2;
    localparam int unsigned FLG_IRQ_EN_POS = 3;
    localparam int unsigned FILE_ADDR_LSB = 8;
    localparam int unsigned LAST_SKIP_POS = 8;

    // Reset values.
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] FILE_WORD_RST = 16'h0000;

    // Decimal adjust constants.
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] BCD_LO_FIX = 9'h006;
    localparam logic [8:0] BCD_HI_FIX = 9'h060;
    localparam logic [4:0] BCD_HI_MAX = 5'h09;
    localparam logic [7:0] ONE = 8'h01;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operations handled by this block.
    typedef enum logic [2:0] {
        OP_NOP,
        OP_ADD,
        OP_DADJ,
        OP_DSZ,
        OP_DEC,
        OP_INC,
        OP_IRQ_OFF,
        OP_IRQ_ON
    } mibio_op_t;

    // One decoded instruction from the fetch stage.
    typedef struct packed {
        mibio_op_t op;
        logic [5:0] addr;
        logic dest;
    } mibio_instr_t;

    // Status and interrupt control bits.
    typedef struct packed {
        logic irq_en;
        logic dc;
        logic z;
        logic c;
    } mibio_flags_t;

    localparam mibio_flags_t FLAGS_RST = 4'h0;

endpackage : mibio_pkg

// ==== verif/mibio_fetch_model.sv ====
// Fetch-side model: streams instructions, one per clock, and counts skips.
// Assumes one bench process calls issue and idle after reset release.
`timescale 1ns/10ps

module mibio_fetch_model
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic SKIP_NEXT,
    output logic INSTR_VALID,
    output mibio_pkg::mibio_instr_t INSTR
);
    import mibio_pkg::*;

    int skips;

    // Quiet bus until the first instruction is offered.
    initial
    begin
        INSTR_VALID = 1'b0;
        INSTR = '0;
        skips = 0;
    end

    // Count cycles with the skip pulse high; a stuck level counts extra.
    always @(posedge CLK_SYS)
    begin
        if (!SRST && SKIP_NEXT)
            skips <= skips + 1;
    end

    // Offer one instruction at the next edge; back to back calls stream.
    task automatic issue(input mibio_op_t op, input logic [5:0] a,
                         input logic d);
        @(posedge CLK_SYS);
        INSTR_VALID <= 1'b1;
        INSTR <= {op, a, d};
    endtask : issue

    // Withdraw and flip the bus so a stale word never looks like a request.
    task automatic idle();
        @(posedge CLK_SYS);
        INSTR_VALID <= 1'b0;
        INSTR <= ~INSTR;
        repeat (3) @(posedge CLK_SYS);
    endtask : idle

endmodule : mibio_fetch_model

// ==== verif/tb.sv ====
// Self-checking bench for the inc/dec, decimal adjust and irq executor.
// Assumes the fetch model beside it and a 100 MHz core clock.
`timescale 1ns/10ps

`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); \
        end \
    end

module tb;
    import mibio_pkg::*;

    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] mask;
        logic [31:0] data;
    } mibio_exp_t;

    logic CLK_SYS, SRST, instr_valid, skip_next, irq_en_out;
    mibio_instr_t instr;
    logic [7:0] acc_out, awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] edge_v [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
    int num_errors = 0;
    int samples_checked = 0;
    mibio_exp_t exp_q[$];

    mibio_core dut_u
    (
        .CLK_SYS(CLK_SYS), .SRST(SRST), .INSTR_VALID(instr_valid),
        .INSTR(instr), .SKIP_NEXT(skip_next), .IRQ_EN_OUT(irq_en_out),
        .ACC_OUT(acc_out), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready)
    );

    mibio_fetch_model fetch_u
    (
        .CLK_SYS(CLK_SYS), .SRST(SRST), .SKIP_NEXT(skip_next),
        .INSTR_VALID(instr_valid), .INSTR(instr)
    );

    // Free-running core clock.
    initial
    begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    // Each read answer retires the oldest expectation noted by the reader.
    always @(posedge CLK_SYS)
    begin
        if (rvalid && rready)
        begin
            `CHK({rresp, rdata & exp_q[0].mask}, {exp_q[0].resp, exp_q[0].data})
            void'(exp_q.pop_front());
        end
    end

    // Write with both channels offered together; each drops when taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
        @(posedge CLK_SYS);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge CLK_SYS);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask : axw

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, 4'hF, RESP_OKAY);
    endtask : wr

    // Note the expectation first, then hold the request until answered.
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m = 32'hFFFFFFFF,
                      input logic [1:0] er = RESP_OKAY);
        exp_q.push_back('{er, m, d & m});
        @(posedge CLK_SYS);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge CLK_SYS);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
    endtask : rd

    task automatic seed(input logic [5:0] a, input logic [7:0] v,
                        input logic [7:0] acc, input logic [3:0] f);
        wr(ADDR_FILE, {18'h0, a, v});
        wr(ADDR_ACC, {24'h0, acc});
        wr(ADDR_FLAGS, {28'h0, f});
    endtask : seed

    // File contents are only visible through the core, so read via INC.
    task automatic probe(input logic [5:0] a, input logic [7:0] e);
        fetch_u.issue(OP_INC, a, 1'b0);
        fetch_u.idle();
        rd(ADDR_ACC, {24'h0, e});
    endtask : probe

    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : bcd

    task automatic finish_test();
        $display("Checks: %0d, errors: %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // Generous bound; the whole sequence needs about 1300 cycles.
    initial
    begin
        #200000;
        num_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end

    // Main sequence: reset, bus refusals, then each operation in turn.
    initial
    begin
        int sa, sb, s, k;
        logic [7:0] v, res;
        logic [5:0] a;
        logic d;
        SRST = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        void'($urandom(82389));
        repeat (6) @(posedge CLK_SYS);
        SRST <= 1'b0;
        rd(ADDR_ACC, 32'h0);
        rd(ADDR_FLAGS, 32'h0);
        `CHK(irq_en_out, 1'b0)
        `CHK(acc_out, 8'h00)
        rd(8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        axw(8'h14, 32'hFF, 4'hF, RESP_SLVERR);
        axw(ADDR_ACC, 32'hAA, 4'h0, RESP_OKAY);
        rd(ADDR_ACC, 32'h0);
        // Irq on and off leave the other flags alone.
        wr(ADDR_FLAGS, 32'h7);
        fetch_u.issue(OP_IRQ_ON, 6'h0, 1'b0);
        fetch_u.idle();
        `CHK(irq_en_out, 1'b1)
        rd(ADDR_FLAGS, 32'hF);
        fetch_u.issue(OP_IRQ_OFF, 6'h0, 1'b0);
        fetch_u.idle();
        `CHK(irq_en_out, 1'b0)
        rd(ADDR_FLAGS, 32'h7);
        // Decimal add: fixed worked case first, then random BCD pairs.
        for (k = 0; k < 24; k++)
        begin
            sa = (k == 0) ? 28 : $urandom % 100;
            sb = (k == 0) ? 25 : $urandom % 100;
            s = sa + sb;
            a = 6'($urandom);
            seed(a, bcd(sb), bcd(sa), 4'h0);
            fetch_u.issue(OP_IRQ_OFF, 6'h0, 1'b0);
            fetch_u.issue(OP_ADD, a, 1'b0);
            fetch_u.issue(OP_DADJ, 6'h0, 1'b0);
            fetch_u.issue(OP_IRQ_ON, 6'h0, 1'b0);
            fetch_u.idle();
            rd(ADDR_ACC, {24'h0, bcd(s % 100)});
            `CHK(acc_out, bcd(s % 100))
            rd(ADDR_FLAGS, {28'h0, 3'b100, s > 99}, 32'h9);
        end
        // Inc and dec at wrap values, both destinations, edge addresses.
        for (k = 0; k < 16; k++)
        begin
            d = k[2];
            v = edge_v[k % 4];
            a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($urandom);
            res = k[3] ? v + 8'h01 : v - 8'h01;
            seed(a, v, 8'h5A, 4'h0);
            fetch_u.issue(k[3] ? OP_INC : OP_DEC, a, d);
            fetch_u.idle();
            rd(ADDR_ACC, {24'h0, d ? 8'h5A : res});
            rd(ADDR_FLAGS, {30'h0, res == 8'h00, 1'b0});
            rd(ADDR_LAST, {24'h0, res});
            `CHK(acc_out, d ? 8'h5A : res)
            probe(a, (d ? res : v) + 8'h01);
        end
        // Dec-skip to zero: the next offered instruction must be dropped.
        for (k = 0; k < 2; k++)
        begin
            d = k[0];
            sa = fetch_u.skips;
            a = 6'($urandom);
            seed(a, 8'h01, 8'h33, 4'h5);
            wr(ADDR_FILE, {18'h0, a ^ 6'h01, 8'h10});
            fetch_u.issue(OP_DSZ, a, d);
            fetch_u.issue(OP_INC, a ^ 6'h01, 1'b0);
            fetch_u.issue(OP_IRQ_ON, 6'h0, 1'b0);
            fetch_u.idle();
            `CHK(fetch_u.skips, sa + 1)
            rd(ADDR_ACC, {24'h0, d ? 8'h33 : 8'h00});
            `CHK(acc_out, d ? 8'h33 : 8'h00)
            rd(ADDR_FLAGS, 32'hD);
            rd(ADDR_LAST, 32'h100);
            probe(a, d ? 8'h01 : 8'h02);
        end
        // Dec-skip wrapping to FF: no skip, the following op still runs.
        sa = fetch_u.skips;
        seed(6'h3F, 8'h00, 8'h33, 4'h2);
        fetch_u.issue(OP_DSZ, 6'h3F, 1'b0);
        fetch_u.issue(OP_IRQ_ON, 6'h0, 1'b0);
        fetch_u.idle();
        `CHK(fetch_u.skips, sa)
        `CHK(irq_en_out, 1'b1)
        rd(ADDR_ACC, 32'hFF);
        rd(ADDR_FLAGS, 32'hA);
        finish_test();
    end

endmodule : tb
